// ==== core/insmt_pkg.sv ====
// Behaviour
// - Normal mode while the sample period setting is 0x09 or less, low-power mode from 0x0A up.
// - Data becomes available 220/290 ms after power-on and 100/170 ms after reset (normal/low power).
// - After sleep, data resumes after 4 ms in normal mode or 15 ms in low-power mode.
// - The flash test finishes after 17 ms in normal mode and 90 ms in low-power mode.
// - A flash update that stores the settings takes 50 ms.
// - The automatic self test takes 12 ms at a sample period setting of 0x01.
// - The output rate follows the sample period setting from 0x01 to 0xFF, 819.2 down to about 3.21 SPS.
// - Data ready follows each external sync pulse by about 600 us.
// - Temperature reads 0x0000 at 25 C with 0.14 C per LSB.
// - Words are 16 bits, MSB first, clock idle high, output on falling edge, input on rising edge.
// - Data ready pulses high at the end of every internal sample cycle while external sync is disabled.
package insmt_pkg;
	localparam int unsigned CLK_HZ       = 50000000;
	localparam logic [7:0]  LP_THRESHOLD = 8'h0A;
	localparam logic [7:0]  SELFTEST_SP  = 8'h01;
	localparam logic [7:0]  PERIOD_RESET = 8'h01;
	localparam int unsigned WORD_BITS    = 16;
	localparam logic [15:0] TEMP_AT_25C  = 16'h0000;
	// Times in their own units
	localparam int unsigned T_PON_N_MS   = 220;
	localparam int unsigned T_PON_L_MS   = 290;
	localparam int unsigned T_RST_N_MS   = 100;
	localparam int unsigned T_RST_L_MS   = 170;
	localparam int unsigned T_SLP_N_MS   = 4;
	localparam int unsigned T_SLP_L_MS   = 15;
	localparam int unsigned T_FT_N_MS    = 17;
	localparam int unsigned T_FT_L_MS    = 90;
	localparam int unsigned T_FU_MS      = 50;
	localparam int unsigned T_ST_MS      = 12;
	localparam int unsigned T_WAKE_US    = 20;
	localparam int unsigned T_SYNC_US    = 600;
	// Base sample period: 1/819.2 SPS = 1220.703125 us, rounded down
	localparam int unsigned T_SAMPLE_NS  = 1220703;
	localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US   = CLK_HZ / 1000000;
	localparam int unsigned C_WAKE       = T_WAKE_US * CYC_PER_US;
	localparam int unsigned C_SYNC       = T_SYNC_US * CYC_PER_US;
	localparam int unsigned C_SAMPLE     = T_SAMPLE_NS / 20;
	localparam int unsigned CW           = 32;
	typedef enum logic [5:0] {
		ST_BOOT  = 6'h01,
		ST_RUN   = 6'h02,
		ST_SLEEP = 6'h04,
		ST_WAKE  = 6'h08,
		ST_BUSY  = 6'h10,
		ST_RECOV = 6'h20
	} insmt_state_t;
	typedef enum logic [1:0] {
		OP_FTEST  = 2'h0,
		OP_FSAVE  = 2'h1,
		OP_STEST  = 2'h2,
		OP_RESET  = 2'h3
	} insmt_op_t;
endpackage

// ==== core/insmt_fifo.sv ====
`timescale 1ns/1ps
module insmt_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	// Wrap-bit pointers only work for power-of-two depths
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
		$error("fifo depth must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire              empty = (wr_q == rd_q);
	wire              push  = ce && in_valid && !full;
	wire              pop   = ce && out_valid && out_ready;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];
	// Storage needs no reset
	always_ff @(posedge clock) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end
	// Pointers with wrap bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule

// ==== core/insmt_core.sv ====
`timescale 1ns/1ps
module insmt_core
	import insmt_pkg::*;
#(
	parameter int unsigned MS_CYC   = insmt_pkg::CYC_PER_MS,
	parameter int unsigned SAMP_CYC = insmt_pkg::C_SAMPLE,
	parameter int unsigned FIFO_D   = 8
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe,
	input  wire logic        external_sync_input,
	input  wire logic        sync_enable,
	input  wire logic [7:0]  sample_period_setting,
	input  wire logic        sleep_req,
	input  wire logic        op_start,
	input  wire logic [1:0]  op_code,
	input  wire logic [15:0] sample_data,
	input  wire logic [15:0] temp_offset_lsb,
	output logic             sample_done_line,
	output logic             low_power,
	output logic             data_avail,
	output logic             op_busy,
	output logic [15:0]      temp_out,
	output logic [15:0]      rx_word,
	output logic             rx_valid
);
	import insmt_pkg::*;
	// Refuse parameters the counters cannot serve
	if (MS_CYC < 1 || SAMP_CYC < 1 || FIFO_D < 2) begin : g_bad_cfg
		$error("core parameters out of range");
	end
	// Reset release through two flops
	logic rs1_q, rs2_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	wire rn = rs2_q;
	// Pin synchronisers, first stage read only by second
	logic [3:0] p1_q, p2_q, p3_q;
	always_ff @(posedge clock or negedge rn) begin
		if (!rn) begin
			p1_q <= 4'hF;
			p2_q <= 4'hF;
			p3_q <= 4'hF;
		end else if (ce) begin
			p1_q <= {external_sync_input, mosi, sclk, cs_n};
			p2_q <= p1_q;
			p3_q <= p2_q;
		end
	end
	wire cs_s    = p2_q[0];
	wire sck_s   = p2_q[1];
	wire sck_p   = p3_q[1];
	wire din_s   = p2_q[2];
	wire sync_rise = p2_q[3] && !p3_q[3];
	wire sck_fall  = sck_p && !sck_s;
	wire sck_rise  = !sck_p && sck_s;
	wire cs_fall   = p3_q[0] && !cs_s;
	assign low_power = (sample_period_setting >= LP_THRESHOLD);
	// Temperature: offset-corrected, zero at 25 C, 0.14 C per LSB
	always_ff @(posedge clock or negedge rn) begin
		if (!rn)
			temp_out <= '0;
		else if (ce)
			temp_out <= temp_offset_lsb - TEMP_AT_25C;
	end
	// Delays in ms, mode-dependent except flash update and self test
	logic [8:0] boot_ms;
	logic       boot_pwr_q;
	insmt_state_t st_q, st_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] msc_q;
	logic [8:0]    ms_q, ms_lim_q;
	wire ms_tick = (msc_q == MS_CYC - 1);
	assign boot_ms = boot_pwr_q ? (low_power ? 9'(T_PON_L_MS) : 9'(T_PON_N_MS))
	                            : (low_power ? 9'(T_RST_L_MS) : 9'(T_RST_N_MS));
	wire [8:0] slp_ms = low_power ? 9'(T_SLP_L_MS) : 9'(T_SLP_N_MS);
	wire [8:0] op_ms  = (op_code == OP_FTEST) ? (low_power ? 9'(T_FT_L_MS) : 9'(T_FT_N_MS))
	                  : (op_code == OP_FSAVE) ? 9'(T_FU_MS)
	                  : (op_code == OP_STEST) ? 9'(T_ST_MS)
	                  : (low_power ? 9'(T_RST_L_MS) : 9'(T_RST_N_MS));
	wire ms_done = ms_tick && (ms_q == ms_lim_q - 9'd1);
	wire wake_ok = (cnt_q >= CW'(C_WAKE));
	// Mode sequencer
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_BOOT:  if (ms_done) st_d = ST_RUN;
			ST_RUN: begin
				if (sleep_req) st_d = ST_SLEEP;
				else if (op_start) st_d = (op_code == OP_RESET) ? ST_BOOT : ST_BUSY;
			end
			ST_SLEEP: if (!cs_s) st_d = ST_WAKE;
			ST_WAKE: begin
				if (cs_s) st_d = wake_ok ? ST_RECOV : ST_SLEEP;
			end
			ST_BUSY:  if (ms_done) st_d = ST_RUN;
			ST_RECOV: if (ms_done) st_d = ST_RUN;
			default:  st_d = ST_BOOT;
		endcase
	end
	wire enter = (st_d != st_q);
	// State and millisecond timer
	always_ff @(posedge clock or negedge rn) begin
		if (!rn) begin
			st_q       <= ST_BOOT;
			boot_pwr_q <= 1'b1;
			msc_q      <= '0;
			ms_q       <= '0;
			ms_lim_q   <= 9'(T_PON_N_MS);
			cnt_q      <= '0;
		end else if (ce) begin
			st_q  <= st_d;
			msc_q <= (enter || ms_tick) ? '0 : msc_q + 1'b1;
			ms_q  <= enter ? 9'd0 : (ms_tick ? ms_q + 9'd1 : ms_q);
			cnt_q <= (st_q == ST_WAKE && !enter) ? cnt_q + 1'b1 : '0;
			if (st_q == ST_BOOT)
				ms_lim_q <= boot_ms;
			else if (st_d == ST_BUSY && enter)
				ms_lim_q <= op_ms;
			else if (st_d == ST_RECOV && enter)
				ms_lim_q <= slp_ms;
			// Soft reset goes straight to boot so recovery is timed only once
			if (st_q == ST_RUN && st_d == ST_BOOT)
				boot_pwr_q <= 1'b0;
		end
	end
	assign data_avail = (st_q == ST_RUN);
	assign op_busy    = (st_q == ST_BUSY);
	// Sample cycle: period scales with setting, 0x00 treated as 0x01
	wire [7:0]     sp_eff = (sample_period_setting == 8'h00) ? 8'h01 : sample_period_setting;
	logic [CW-1:0] smp_q, syn_q;
	logic          syn_arm_q, done_q;
	wire [CW-1:0]  smp_lim = CW'(SAMP_CYC) * CW'(sp_eff);
	wire int_done  = !sync_enable && (smp_q >= smp_lim - 1'b1);
	wire sync_done = sync_enable && syn_arm_q && (syn_q == CW'(C_SYNC) - 1'b1);
	always_ff @(posedge clock or negedge rn) begin
		if (!rn) begin
			smp_q     <= '0;
			syn_q     <= '0;
			syn_arm_q <= 1'b0;
			done_q    <= 1'b0;
		end else if (ce) begin
			smp_q  <= (!data_avail || int_done) ? '0 : smp_q + 1'b1;
			done_q <= data_avail && (int_done || sync_done);
			if (sync_rise && data_avail) begin
				syn_arm_q <= 1'b1;
				syn_q     <= '0;
			end else if (sync_done) begin
				syn_arm_q <= 1'b0;
			end else if (syn_arm_q) begin
				syn_q <= syn_q + 1'b1;
			end
		end
	end
	assign sample_done_line = done_q;
	// Samples queue for the serial port
	logic [15:0] fq_data;
	logic        fq_valid, fq_ready, fq_in_ready;
	insmt_fifo #(.WIDTH(16), .DEPTH(FIFO_D)) u_fifo (
		.clock     (clock),
		.rst_n     (rn),
		.ce        (ce),
		.in_data   (sample_data),
		.in_valid  (done_q),
		.in_ready  (fq_in_ready),
		.out_data  (fq_data),
		.out_valid (fq_valid),
		.out_ready (fq_ready)
	);
	// Full queue drops newest sample: sensors cannot stall
	// Serial shifter: MSB first, drive on fall, sample on rise
	logic [15:0] tx_q, rxs_q;
	logic [4:0]  bit_q;
	logic        held_q;
	wire         word_end = sck_rise && (bit_q == 5'(WORD_BITS - 1));
	// Burst word loads on the first fall after a word, not at its end:
	// a frame that stops after one word must not swallow the next sample
	wire         next_ld  = !cs_s && sck_fall && (bit_q == 5'd0) && !held_q;
	wire         load     = cs_fall || next_ld;
	assign fq_ready = load && fq_valid;
	always_ff @(posedge clock or negedge rn) begin
		if (!rn) begin
			tx_q     <= '0;
			rxs_q    <= '0;
			bit_q    <= '0;
			rx_word  <= '0;
			rx_valid <= 1'b0;
			miso     <= 1'b0;
			held_q   <= 1'b0;
		end else if (ce) begin
			rx_valid <= 1'b0;
			if (cs_s) begin
				bit_q  <= '0;
				held_q <= 1'b0;
			end else begin
				if (sck_rise) begin
					rxs_q <= {rxs_q[14:0], din_s};
					bit_q <= word_end ? 5'd0 : bit_q + 5'd1;
				end
				if (word_end) begin
					rx_word  <= {rxs_q[14:0], din_s};
					rx_valid <= 1'b1;
					held_q   <= 1'b0;
				end
				if (sck_fall && bit_q != 5'd0)
					miso <= tx_q[15];
				if (sck_fall && bit_q != 5'd0)
					tx_q <= {tx_q[14:0], 1'b0};
			end
			if (load) begin
				held_q <= 1'b1;
				tx_q <= fq_valid ? {fq_data[14:0], 1'b0} : 16'h0000;
				miso <= fq_valid ? fq_data[15] : 1'b0;
			end
		end
	end
	assign miso_oe = !cs_s;
	// Low-power flag follows the setting threshold
	property p_lowpower;
		@(posedge clock) disable iff (!rn)
		low_power == (sample_period_setting > 8'h09);
	endproperty
	a_lowpower: assert property (p_lowpower) else $error("mode threshold wrong");
	property p_done_pulse;
		@(posedge clock) disable iff (!rn)
		sample_done_line |=> !sample_done_line;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
	property p_sync_delay;
		@(posedge clock) disable iff (!rn)
		(ce && sync_done) |=> sample_done_line;
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync ready missing");
	property p_boot_quiet;
		@(posedge clock) disable iff (!rn)
		(st_q == ST_BOOT) |-> !data_avail && !sample_done_line;
	endproperty
	a_boot_quiet: assert property (p_boot_quiet) else $error("data before boot end");
	property p_recov_quiet;
		@(posedge clock) disable iff (!rn)
		(st_q == ST_RECOV) |-> !data_avail;
	endproperty
	a_recov_quiet: assert property (p_recov_quiet) else $error("data during recovery");
	property p_busy_len;
		@(posedge clock) disable iff (!rn)
		$rose(op_busy) |-> op_busy[*8];
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("operation ended early");
	property p_sleep_hold;
		@(posedge clock) disable iff (!rn)
		(st_q == ST_WAKE && cs_s && !wake_ok) |=> (st_q == ST_SLEEP);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("short wake accepted");
	property p_rx_word;
		@(posedge clock) disable iff (!rn)
		rx_valid |-> $past(bit_q) == 5'd15;
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("word not 16 bits");
endmodule

// ==== testbench/insmt_host_model.sv ====
`timescale 1ns/1ps
module insmt_host_model #(
	parameter int HALF = 4
) (
	input  wire logic       clock,
	input  wire logic [7:0] sample_period_setting,
	input  wire logic       miso,
	output logic            cs_n,
	output logic            sclk,
	output logic            mosi,
	output logic            sync
);
	// Select and clock idle high
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		mosi = 1'b0;
		sync = 1'b0;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Word gap follows the mode of the setting last written
	function automatic int gap_cyc();
		return (sample_period_setting >= 8'h0A) ? 3750 : 450;
	endfunction
	// Low power needs a slow link clock; otherwise the bench's link period
	function automatic int half_cyc();
		return (sample_period_setting >= 8'h0A) ? 84 : HALF;
	endfunction
	// One word each way, msb first; change on fall, sample after rise
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge clock);
		cs_n <= 1'b0;
		wait_cyc(3);
		for (int i = 15; i >= 0; i--) begin
			sclk <= 1'b0;
			mosi <= tx[i];
			wait_cyc(half_cyc());
			sclk <= 1'b1;
			@(negedge clock);
			rx[i] = miso;
			wait_cyc(half_cyc());
		end
		cs_n <= 1'b1;
		mosi <= ~tx[0]; // Released line must not keep last bit
		wait_cyc(gap_cyc());
	endtask
	// Long select pulse wakes a sleeping device
	task automatic wake(input int n);
		@(posedge clock);
		cs_n <= 1'b0;
		wait_cyc(n);
		cs_n <= 1'b1;
	endtask
	// Single pulse of 5 us; only one is sent, so spacing holds trivially
	task automatic sync_pulse();
		@(posedge clock);
		sync <= 1'b1;
		wait_cyc(250);
		sync <= 1'b0;
	endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	import insmt_pkg::*;
	localparam int MS = 50;
	localparam int SC = 20;
	logic        clock, rst_n, cs_n, sclk, mosi, miso, miso_oe, sync, sync_en;
	logic        sleep_req, op_start, done, low_power, data_avail, op_busy, rx_valid;
	logic [1:0]  op_code;
	logic [7:0]  setting;
	logic [15:0] sample_data, temp_in, temp_out, rx_word, rx_seen, rx;
	int          miscompares, samples_checked, n;

	insmt_core #(.MS_CYC(MS), .SAMP_CYC(SC), .FIFO_D(8)) DUT (
		.clock(clock), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sclk(sclk),
		.mosi(mosi), .miso(miso), .miso_oe(miso_oe), .external_sync_input(sync),
		.sync_enable(sync_en), .sample_period_setting(setting),
		.sleep_req(sleep_req), .op_start(op_start), .op_code(op_code),
		.sample_data(sample_data), .temp_offset_lsb(temp_in),
		.sample_done_line(done), .low_power(low_power), .data_avail(data_avail),
		.op_busy(op_busy), .temp_out(temp_out), .rx_word(rx_word), .rx_valid(rx_valid));
	insmt_host_model host (
		.clock(clock), .sample_period_setting(setting), .miso(miso),
		.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .sync(sync));

	// Keep the last received word for later comparison
	always @(posedge clock) if (rx_valid === 1'b1) rx_seen <= rx_word;
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Durations are typical figures, so allow a small spread
	function automatic logic near(input int got, input int exp);
		return got >= exp * 98 / 100 && got <= exp * 102 / 100 + 8;
	endfunction
	// Cycles until an output reaches a level, capped so a hang cannot stall
	task automatic cyc_until(ref logic s, input logic lvl, input int lim, output int c);
		c = 0;
		while (s !== lvl && c < lim) begin
			@(negedge clock);
			c++;
		end
	endtask
	task automatic start_op(input logic [1:0] code);
		@(posedge clock);
		op_code <= code;
		op_start <= 1'b1;
		@(posedge clock);
		op_start <= 1'b0;
	endtask
	task automatic t_mode();
		logic [7:0] sv [4] = '{8'h09, 8'h0A, 8'hFF, 8'h01};
		logic       lp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			setting <= sv[i];
			repeat (2) @(negedge clock);
			check(low_power, lp[i]);
		end
	endtask
	task automatic t_temp();
		@(posedge clock);
		temp_in <= 16'h0000;
		repeat (3) @(negedge clock);
		check(temp_out, 16'h0000);
		@(posedge clock);
		temp_in <= 16'h00B3;
		repeat (3) @(negedge clock);
		check(temp_out, 16'h00B3);
	endtask
	task automatic t_rate();
		int sv [2] = '{1, 9};
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			setting <= 8'(sv[i]);
			repeat (2) begin
				cyc_until(done, 1'b1, 400, n);
				@(negedge clock);
			end
			cyc_until(done, 1'b1, 400, n);
			check(n + 1, SC * sv[i]);
		end
	endtask
	// Fill the queue, then refuse new words until the host reads one
	task automatic t_fifo();
		@(posedge clock);
		setting <= 8'h01;
		sample_data <= 16'hC35A;
		repeat (400) @(posedge clock);
		setting <= 8'h09;
		sample_data <= 16'h1E87;
		for (int i = 0; i < 8; i++) begin
			host.xfer(16'h3C00 + 16'(i), rx);
			check(rx, 16'hC35A);
			check(rx_seen, 16'h3C00 + 16'(i));
		end
		host.xfer(16'hA5F0, rx);
		check(rx, 16'h1E87);
	endtask
	task automatic t_ops();
		int ms [4] = '{17, 50, 12, 90};
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			setting <= (i == 3) ? 8'h0A : 8'h01;
			start_op((i == 3) ? 2'h0 : 2'(i));
			cyc_until(op_busy, 1'b1, 10, n);
			cyc_until(op_busy, 1'b0, 6000, n);
			check(near(n, ms[i] * MS), 1'b1);
		end
		@(posedge clock);
		setting <= 8'h01;
	endtask
	// Soft reset in both modes
	task automatic t_reset();
		logic [7:0] sv [2] = '{8'h01, 8'h0A};
		int         ms [2] = '{100, 170};
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			setting <= sv[i];
			start_op(2'h3);
			cyc_until(data_avail, 1'b0, 10, n);
			cyc_until(data_avail, 1'b1, 10000, n);
			check(near(n, ms[i] * MS), 1'b1);
		end
		@(posedge clock);
		setting <= 8'h01;
	endtask
	// Short select pulse must not wake; a long one does, in both modes
	task automatic t_sleep();
		logic [7:0] sv [2] = '{8'h01, 8'h0A};
		int         ms [2] = '{4, 15};
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			setting <= sv[i];
			sleep_req <= 1'b1;
			@(posedge clock);
			sleep_req <= 1'b0;
			cyc_until(data_avail, 1'b0, 20, n);
			check(data_avail, 1'b0);
			host.wake(500);
			cyc_until(data_avail, 1'b1, 300, n);
			check(data_avail, 1'b0);
			fork
				host.wake(1010);
				begin
					repeat (10) @(negedge clock);
					check(miso_oe, 1'b1);
				end
			join
			cyc_until(data_avail, 1'b1, 2000, n);
			check(n >= ms[i] * MS * 3 / 4 && n <= ms[i] * MS + 10, 1'b1);
		end
		@(posedge clock);
		setting <= 8'h01;
	endtask
	task automatic t_sync();
		@(posedge clock);
		sync_en <= 1'b1;
		host.sync_pulse();
		cyc_until(done, 1'b1, 31000, n);
		check(near(n + 250, 600 * CYC_PER_US), 1'b1);
		@(posedge clock);
		sync_en <= 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog: the run needs about three quarters of this span
	initial begin
		#1900000;
		miscompares++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		sync_en = 1'b0;
		sleep_req = 1'b0;
		op_start = 1'b0;
		op_code = 2'h0;
		setting = 8'h01;
		sample_data = 16'hC35A;
		temp_in = 16'h0000;
		miscompares = 0;
		samples_checked = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		cyc_until(data_avail, 1'b1, 20000, n);
		check(near(n, 220 * MS), 1'b1);
		check(miso_oe, 1'b0);
		t_mode();
		t_temp();
		t_rate();
		t_fifo();
		t_ops();
		t_reset();
		t_sleep();
		t_sync();
		conclude();
	end
endmodule
